// [hw/dtc_timer.sv]
// dual 8-bit compare timer with axi4-lite register slave
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
module dtc_timer (
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire dtc_pkg::dtc_axi_req_t i_axi,
   output dtc_pkg::dtc_axi_rsp_t o_axi,
   input wire logic [1:0] i_ext_clk,
   input wire logic [1:0] i_ext_clear,
   input wire logic [1:0] i_xfer_start_a,
   input wire logic [1:0] i_xfer_start_b,
   input wire logic i_transfer_disable_select,
   output logic [1:0] o_wave_out,
   output logic [1:0] o_match_a_request,
   output logic [1:0] o_match_b_request,
   output logic [1:0] o_wrap_request,
   output logic o_conv_start
);
   import dtc_pkg::*;

   function automatic logic fall_tap(input logic [DTC_PRESC_W-1:0] p, input int unsigned n);
      logic all1;
      all1 = 1'b1;
      for (int i = 0; i < DTC_PRESC_W; i++) begin
         if (i < n) begin
            all1 = all1 & p[i];
         end
      end
      return all1;
   endfunction

   // count pulse of one channel from its own source; cascade handled outside
   function automatic logic own_tick(input logic [2:0] cks, input logic f8, input logic f64,
                                     input logic f8k, input logic rise, input logic fall);
      logic t;
      case (cks)
         DTC_CKS_DIV8: t = f8;
         DTC_CKS_DIV64: t = f64;
         DTC_CKS_DIV8192: t = f8k;
         DTC_CKS_EXT_RISE: t = rise;
         DTC_CKS_EXT_FALL: t = fall;
         DTC_CKS_EXT_BOTH: t = rise | fall;
         default: t = 1'b0;
      endcase
      return t;
   endfunction

   function automatic logic [1:0] pick_action(input logic ma, input logic [1:0] sa,
                                              input logic mb, input logic [1:0] sb);
      logic [1:0] a;
      logic [1:0] b;
      a = ma ? sa : DTC_OUT_KEEP;
      b = mb ? sb : DTC_OUT_KEEP;
      return (a > b) ? a : b;
   endfunction

   function automatic logic clear_hit(input logic [1:0] sel, input logic ma, input logic mb,
                                      input logic ext);
      logic c;
      case (sel)
         DTC_CLR_MATCH_A: c = ma;
         DTC_CLR_MATCH_B: c = mb;
         DTC_CLR_EXT: c = ext;
         default: c = 1'b0;
      endcase
      return c;
   endfunction

   // registers
   logic [7:0] count [2], const_a [2], const_b [2], ctrl [2];
   logic [1:0] flag_a, flag_b, flag_wrap, arm_a, arm_b, arm_wrap;
   logic trig_en;
   logic [3:0] osel [2];
   logic [15:0] stop_reg;
   logic [DTC_PRESC_W-1:0] presc;
   logic [1:0] wave;
   // pin synchronisers plus an edge-history stage
   logic [1:0] clk_s1, clk_s2, clk_s3;
   logic [1:0] clr_s1, clr_s2, clr_s3;

   // bus holding state
   logic have_aw, have_w, bvalid, rvalid;
   logic [DTC_ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;

   wire stopped = stop_reg[DTC_BIT_STOP];
   wire running = ~stopped;
   // write decode
   wire wr_do = have_aw & have_w & ~bvalid;
   wire [DTC_IDX_W-1:0] wr_idx = aw_addr[DTC_IDX_W+1:2];
   wire wr_map = (aw_addr[1:0] == 2'b00) && (aw_addr <= DTC_OFS_STOP);
   wire wr_stopreg = wr_do & wr_map & (aw_addr == DTC_OFS_STOP);
   wire wr_timer = wr_do & wr_map & (aw_addr != DTC_OFS_STOP) & running & w_strb[0];
   wire [7:0] wb = w_data[7:0];

   // read decode
   wire rd_take = i_axi.arvalid & ~rvalid;
   wire rd_map = (i_axi.araddr[1:0] == 2'b00) && (i_axi.araddr <= DTC_OFS_STOP);
   wire rd_is_stop = i_axi.araddr == DTC_OFS_STOP;
   wire rd_ok = rd_map & (rd_is_stop | running);

   logic [7:0] stat_rd [2];
   assign stat_rd[0] = {flag_b[0], flag_a[0], flag_wrap[0], trig_en, osel[0]};
   assign stat_rd[1] = {flag_b[1], flag_a[1], flag_wrap[1], 1'b1, osel[1]};

   logic [31:0] rd_val;
   always_comb begin
      case (i_axi.araddr)
         DTC_OFS_COUNT0: rd_val = {24'h000000, count[0]};
         DTC_OFS_COUNT1: rd_val = {24'h000000, count[1]};
         DTC_OFS_CONSTA0: rd_val = {24'h000000, const_a[0]};
         DTC_OFS_CONSTA1: rd_val = {24'h000000, const_a[1]};
         DTC_OFS_CONSTB0: rd_val = {24'h000000, const_b[0]};
         DTC_OFS_CONSTB1: rd_val = {24'h000000, const_b[1]};
         DTC_OFS_CTRL0: rd_val = {24'h000000, ctrl[0]};
         DTC_OFS_CTRL1: rd_val = {24'h000000, ctrl[1]};
         DTC_OFS_STAT0: rd_val = {24'h000000, stat_rd[0]};
         DTC_OFS_STAT1: rd_val = {24'h000000, stat_rd[1]};
         DTC_OFS_STOP: rd_val = {16'h0000, stop_reg};
         default: rd_val = 32'h00000000;
      endcase
   end

   // prescaler taps: falling edge of divided clock when low bits are all ones
   wire f8 = running & fall_tap(presc, DTC_DIV8_BITS);
   wire f64 = running & fall_tap(presc, DTC_DIV64_BITS);
   wire f8k = running & fall_tap(presc, DTC_DIV8192_BITS);

   wire [1:0] ext_rise = clk_s2 & ~clk_s3;
   wire [1:0] ext_fall = ~clk_s2 & clk_s3;
   wire [1:0] ext_clr = clr_s2 & ~clr_s3 & {2{running}};

   wire mode16 = (ctrl[0][2:0] == DTC_CKS_CASCADE) & (ctrl[1][2:0] != DTC_CKS_CASCADE);
   wire mcount = (ctrl[1][2:0] == DTC_CKS_CASCADE) & (ctrl[0][2:0] != DTC_CKS_CASCADE);

   logic [1:0] own, eq_a, eq_b, wr_ca, wr_cb, wr_cnt, wr_stat, wr_ctl;
   for (genvar c = 0; c < 2; c++) begin : g_ch
      assign own[c] = running & own_tick(ctrl[c][2:0], f8, f64, f8k,
                                        ext_rise[c], ext_fall[c]);
      assign wr_ca[c] = wr_timer & (wr_idx == DTC_OFS_CONSTA0[5:2] + 4'(c));
      assign wr_cb[c] = wr_timer & (wr_idx == DTC_OFS_CONSTB0[5:2] + 4'(c));
      assign wr_cnt[c] = wr_timer & (wr_idx == DTC_OFS_COUNT0[5:2] + 4'(c));
      assign wr_ctl[c] = wr_timer & (wr_idx == DTC_OFS_CTRL0[5:2] + 4'(c));
      assign wr_stat[c] = wr_timer & (wr_idx == DTC_OFS_STAT0[5:2] + 4'(c));
      // a constant being written this cycle suppresses its compare
      assign eq_a[c] = (count[c] == const_a[c]) & ~wr_ca[c];
      assign eq_b[c] = (count[c] == const_b[c]) & ~wr_cb[c];
   end

   // cascade sources; with both codes set neither side gets a pulse
   wire tick1 = mcount ? (eq_a[0] & own[0]) : own[1];
   wire tick0 = mode16 ? (own[1] & (count[1] == 8'hff)) : own[0];

   // matches are taken on the count edge, i.e. the last state of equality
   wire match_a0 = mode16 ? (eq_a[0] & eq_a[1] & own[1]) : (eq_a[0] & tick0);
   wire match_b0 = mode16 ? (eq_b[0] & eq_b[1] & own[1]) : (eq_b[0] & tick0);
   wire match_a1 = eq_a[1] & tick1;
   wire match_b1 = eq_b[1] & tick1;
   wire [1:0] match_a = {match_a1, match_a0};
   wire [1:0] match_b = {match_b1, match_b0};

   wire clr0 = clear_hit(ctrl[0][4:3], match_a0, match_b0, ext_clr[0]);
   wire clr1_own = clear_hit(ctrl[1][4:3], match_a1, match_b1, ext_clr[1]);
   wire clr1 = mode16 ? clr0 : clr1_own;
   wire [1:0] clr = {clr1, clr0};
   wire [1:0] tick = {tick1, tick0};

   logic [1:0] wrap_ev;
   assign wrap_ev[1] = tick1 & (count[1] == 8'hff) & ~clr1 & ~wr_cnt[1];
   assign wrap_ev[0] = tick0 & (count[0] == 8'hff) & ~clr0 & ~wr_cnt[0];

   // flag clearing: read while one arms, a later zero write clears
   logic [1:0] clr_fa, clr_fb, clr_fw;
   for (genvar c = 0; c < 2; c++) begin : g_flag
      assign clr_fa[c] = (wr_stat[c] & ~wb[DTC_BIT_FLAG_A] & arm_a[c])
                         | (i_xfer_start_a[c] & ~i_transfer_disable_select);
      assign clr_fb[c] = (wr_stat[c] & ~wb[DTC_BIT_FLAG_B] & arm_b[c])
                         | (i_xfer_start_b[c] & ~i_transfer_disable_select);
      assign clr_fw[c] = wr_stat[c] & ~wb[DTC_BIT_WRAP] & arm_wrap[c];
   end

   logic [1:0] rd_stat;
   assign rd_stat[0] = rd_take & rd_ok & (i_axi.araddr == DTC_OFS_STAT0);
   assign rd_stat[1] = rd_take & rd_ok & (i_axi.araddr == DTC_OFS_STAT1);

   // waveform next value
   logic [1:0] act [2];
   logic [1:0] next_wave;
   for (genvar c = 0; c < 2; c++) begin : g_out
      assign act[c] = pick_action(match_a[c], osel[c][1:0], match_b[c], osel[c][3:2]);
      always_comb begin
         case (act[c])
            DTC_OUT_ZERO: next_wave[c] = 1'b0;
            DTC_OUT_ONE: next_wave[c] = 1'b1;
            DTC_OUT_TOGGLE: next_wave[c] = ~wave[c];
            default: next_wave[c] = wave[c];
         endcase
      end
   end

   // synchronisers and prescaler
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         clk_s1 <= 2'h0;
         clk_s2 <= 2'h0;
         clk_s3 <= 2'h0;
         clr_s1 <= 2'h0;
         clr_s2 <= 2'h0;
         clr_s3 <= 2'h0;
         presc <= 13'h0000;
      end else begin
         clk_s1 <= i_ext_clk;
         clk_s2 <= clk_s1;
         clk_s3 <= clk_s2;
         clr_s1 <= i_ext_clear;
         clr_s2 <= clr_s1;
         clr_s3 <= clr_s2;
         if (running) begin
            presc <= presc + 13'h0001;
         end
      end
   end

   // per-channel counter, constants, control
   for (genvar c = 0; c < 2; c++) begin : g_reg
      always_ff @(posedge i_core_clk) begin
         if (i_reset) begin
            count[c] <= DTC_RST_COUNT;
            const_a[c] <= DTC_RST_CONST;
            const_b[c] <= DTC_RST_CONST;
            ctrl[c] <= DTC_RST_CTRL;
            osel[c] <= DTC_RST_STAT_CTL[3:0];
            wave[c] <= 1'b0;
         end else begin
            // clear beats a bus write, which beats the increment
            if (clr[c]) begin
               count[c] <= 8'h00;
            end else if (wr_cnt[c]) begin
               count[c] <= wb;
            end else if (tick[c]) begin
               count[c] <= count[c] + 8'h01;
            end
            if (wr_ca[c]) begin
               const_a[c] <= wb;
            end
            if (wr_cb[c]) begin
               const_b[c] <= wb;
            end
            if (wr_ctl[c]) begin
               ctrl[c] <= wb;
            end
            if (wr_stat[c]) begin
               osel[c] <= wb[3:0];
            end
            wave[c] <= next_wave[c];
         end
      end
   end

   // flags: a set in the same cycle as a clear wins
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         flag_a <= 2'h0;
         flag_b <= 2'h0;
         flag_wrap <= 2'h0;
         arm_a <= 2'h0;
         arm_b <= 2'h0;
         arm_wrap <= 2'h0;
         trig_en <= DTC_RST_STAT_CTL[DTC_BIT_TRIG];
         o_conv_start <= 1'b0;
      end else begin
         o_conv_start <= match_a0 & trig_en;
         flag_a <= match_a | (flag_a & ~clr_fa);
         flag_b <= match_b | (flag_b & ~clr_fb);
         flag_wrap <= wrap_ev | (flag_wrap & ~clr_fw);
         arm_a <= (rd_stat & flag_a) | (arm_a & ~wr_stat);
         arm_b <= (rd_stat & flag_b) | (arm_b & ~wr_stat);
         arm_wrap <= (rd_stat & flag_wrap) | (arm_wrap & ~wr_stat);
         if (wr_stat[0]) begin
            trig_en <= wb[DTC_BIT_TRIG];
         end
      end
   end

   // request levels follow flag and enable
   for (genvar c = 0; c < 2; c++) begin : g_req
      assign o_match_a_request[c] = flag_a[c] & ctrl[c][DTC_BIT_EN_A];
      assign o_match_b_request[c] = flag_b[c] & ctrl[c][DTC_BIT_EN_B];
      assign o_wrap_request[c] = flag_wrap[c] & ctrl[c][DTC_BIT_EN_WRAP];
   end
   assign o_wave_out = wave;

   // module stop register: reachable even while the timer is stopped
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         stop_reg <= DTC_RST_STOP;
      end else if (wr_stopreg) begin
         if (w_strb[0]) begin
            stop_reg[7:0] <= w_data[7:0];
         end
         if (w_strb[1]) begin
            stop_reg[15:8] <= w_data[15:8];
         end
      end
   end

   // axi4-lite write path: address and data taken independently
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         have_aw <= 1'b0;
         have_w <= 1'b0;
         bvalid <= 1'b0;
         bresp <= DTC_RESP_OKAY;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else begin
         if (i_axi.awvalid & ~have_aw & ~bvalid) begin
            have_aw <= 1'b1;
            aw_addr <= i_axi.awaddr;
         end
         if (i_axi.wvalid & ~have_w & ~bvalid) begin
            have_w <= 1'b1;
            w_data <= i_axi.wdata;
            w_strb <= i_axi.wstrb;
         end
         if (wr_do) begin
            have_aw <= 1'b0;
            have_w <= 1'b0;
            bvalid <= 1'b1;
            // unmapped, or timer register while stopped: error, no effect
            bresp <= (wr_map & ((aw_addr == DTC_OFS_STOP) | running)) ?
                     DTC_RESP_OKAY : DTC_RESP_SLVERR;
         end else if (bvalid & i_axi.bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // axi4-lite read path: one cycle to rvalid
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= DTC_RESP_OKAY;
      end else if (rd_take) begin
         rvalid <= 1'b1;
         rdata <= rd_ok ? rd_val : 32'h00000000;
         rresp <= rd_ok ? DTC_RESP_OKAY : DTC_RESP_SLVERR;
      end else if (rvalid & i_axi.rready) begin
         rvalid <= 1'b0;
      end
   end

   assign o_axi.awready = ~have_aw & ~bvalid;
   assign o_axi.wready = ~have_w & ~bvalid;
   assign o_axi.bvalid = bvalid;
   assign o_axi.bresp = bresp;
   assign o_axi.arready = ~rvalid;
   assign o_axi.rvalid = rvalid;
   assign o_axi.rdata = rdata;
   assign o_axi.rresp = rresp;

endmodule

// [hw/dtc_pkg.sv]
// constants, register map and bus carriers of the dual 8-bit compare timer
package dtc_pkg;

   localparam int unsigned DTC_ADDR_W = 8;
   localparam int unsigned DTC_IDX_W = 4;

   // register byte offsets
   localparam logic [7:0] DTC_OFS_COUNT0 = 8'h00;
   localparam logic [7:0] DTC_OFS_COUNT1 = 8'h04;
   localparam logic [7:0] DTC_OFS_CONSTA0 = 8'h08;
   localparam logic [7:0] DTC_OFS_CONSTA1 = 8'h0c;
   localparam logic [7:0] DTC_OFS_CONSTB0 = 8'h10;
   localparam logic [7:0] DTC_OFS_CONSTB1 = 8'h14;
   localparam logic [7:0] DTC_OFS_CTRL0 = 8'h18;
   localparam logic [7:0] DTC_OFS_CTRL1 = 8'h1c;
   localparam logic [7:0] DTC_OFS_STAT0 = 8'h20;
   localparam logic [7:0] DTC_OFS_STAT1 = 8'h24;
   localparam logic [7:0] DTC_OFS_STOP = 8'h28;

   // reset values
   localparam logic [7:0] DTC_RST_COUNT = 8'h00;
   localparam logic [7:0] DTC_RST_CONST = 8'hff;
   localparam logic [7:0] DTC_RST_CTRL = 8'h00;
   localparam logic [4:0] DTC_RST_STAT_CTL = 5'h00;
   localparam logic [15:0] DTC_RST_STOP = 16'h3fff;

   // field positions
   localparam int unsigned DTC_BIT_FLAG_B = 7;
   localparam int unsigned DTC_BIT_FLAG_A = 6;
   localparam int unsigned DTC_BIT_WRAP = 5;
   localparam int unsigned DTC_BIT_TRIG = 4;
   localparam int unsigned DTC_BIT_EN_B = 7;
   localparam int unsigned DTC_BIT_EN_A = 6;
   localparam int unsigned DTC_BIT_EN_WRAP = 5;
   localparam int unsigned DTC_BIT_STOP = 12;

   // prescaler taps: divide by 8, 64, 8192
   localparam int unsigned DTC_PRESC_W = 13;
   localparam int unsigned DTC_DIV8_BITS = 3;
   localparam int unsigned DTC_DIV64_BITS = 6;
   localparam int unsigned DTC_DIV8192_BITS = 13;

   localparam logic [1:0] DTC_RESP_OKAY = 2'h0;
   localparam logic [1:0] DTC_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      DTC_CKS_OFF = 3'b000,
      DTC_CKS_DIV8 = 3'b001,
      DTC_CKS_DIV64 = 3'b010,
      DTC_CKS_DIV8192 = 3'b011,
      DTC_CKS_CASCADE = 3'b100,
      DTC_CKS_EXT_RISE = 3'b101,
      DTC_CKS_EXT_FALL = 3'b110,
      DTC_CKS_EXT_BOTH = 3'b111
   } dtc_cks_t;

   typedef enum logic [1:0] {
      DTC_CLR_NONE = 2'b00,
      DTC_CLR_MATCH_A = 2'b01,
      DTC_CLR_MATCH_B = 2'b10,
      DTC_CLR_EXT = 2'b11
   } dtc_clr_t;

   // output action codes; numeric order equals priority
   typedef enum logic [1:0] {
      DTC_OUT_KEEP = 2'b00,
      DTC_OUT_ZERO = 2'b01,
      DTC_OUT_ONE = 2'b10,
      DTC_OUT_TOGGLE = 2'b11
   } dtc_out_t;

   typedef struct packed {
      logic [DTC_ADDR_W-1:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [DTC_ADDR_W-1:0] araddr;
      logic arvalid;
      logic rready;
   } dtc_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } dtc_axi_rsp_t;

endpackage

// [test/dtc_timer_checker.sv]
// port checker of the dual compare timer
module dtc_timer_checker (
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire dtc_pkg::dtc_axi_req_t i_axi,
   input wire dtc_pkg::dtc_axi_rsp_t o_axi,
   input wire logic [1:0] i_xfer_start_a,
   input wire logic [1:0] i_xfer_start_b,
   input wire logic i_transfer_disable_select,
   input wire logic [1:0] o_wave_out,
   input wire logic [1:0] o_match_a_request,
   input wire logic [1:0] o_match_b_request,
   input wire logic [1:0] o_wrap_request,
   input wire logic o_conv_start
);
   import dtc_pkg::*;
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_reset);
   sequence s_rd_take;
      i_axi.arvalid && o_axi.arready;
   endsequence
   sequence s_wr_take;
      i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready;
   endsequence
   property p_reset_quiet;
      $fell(i_reset) |-> o_wave_out == 2'h0 && !o_conv_start && !o_axi.bvalid
         && !o_axi.rvalid && o_match_a_request == 2'h0 && o_wrap_request == 2'h0;
   endproperty
   property p_rd_answer;
      s_rd_take |=> o_axi.rvalid;
   endproperty
   property p_wr_answer;
      s_wr_take |-> ##[1:2] o_axi.bvalid;
   endproperty
   property p_rd_hold;
      o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata);
   endproperty
   property p_wr_hold;
      o_axi.bvalid && !i_axi.bready |=> o_axi.bvalid && $stable(o_axi.bresp);
   endproperty
   property p_conv_pulse;
      o_conv_start |=> !o_conv_start;
   endproperty
   // guard on the past reset: a one-edge reset drops flags without a bus write
   property p_wrap_drop;
      !$past(i_reset) && |($past(o_wrap_request) & ~o_wrap_request) |-> o_axi.bvalid;
   endproperty
   property p_a_drop;
      !$past(i_reset) && |($past(o_match_a_request) & ~o_match_a_request) |-> o_axi.bvalid
         || $past(|i_xfer_start_a && !i_transfer_disable_select);
   endproperty
   property p_b_drop;
      !$past(i_reset) && |($past(o_match_b_request) & ~o_match_b_request) |-> o_axi.bvalid
         || $past(|i_xfer_start_b && !i_transfer_disable_select);
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs not idle after reset");
   a_rd_answer: assert property (p_rd_answer)
      else $error("read answer late");
   a_wr_answer: assert property (p_wr_answer)
      else $error("write answer late");
   a_rd_hold: assert property (p_rd_hold)
      else $error("read answer not held");
   a_wr_hold: assert property (p_wr_hold)
      else $error("write answer not held");
   a_conv_pulse: assert property (p_conv_pulse)
      else $error("converter start longer than one cycle");
   a_wrap_drop: assert property (p_wrap_drop)
      else $error("wrap request dropped without a write");
   a_a_drop: assert property (p_a_drop)
      else $error("match a request dropped without cause");
   a_b_drop: assert property (p_b_drop)
      else $error("match b request dropped without cause");
endmodule

bind dtc_timer dtc_timer_checker dtc_timer_checker_i (
   .i_core_clk(i_core_clk),
   .i_reset(i_reset),
   .i_axi(i_axi),
   .o_axi(o_axi),
   .i_xfer_start_a(i_xfer_start_a),
   .i_xfer_start_b(i_xfer_start_b),
   .i_transfer_disable_select(i_transfer_disable_select),
   .o_wave_out(o_wave_out),
   .o_match_a_request(o_match_a_request),
   .o_match_b_request(o_match_b_request),
   .o_wrap_request(o_wrap_request),
   .o_conv_start(o_conv_start)
);

// [test/dtc_partner.sv]
// external count clock and clear source of the timer
module dtc_partner (
   input wire logic i_core_clk,
   output logic [1:0] o_ext_clk,
   output logic [1:0] o_ext_clear
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_ext_clk = 2'h0;
      o_ext_clear = 2'h0;
   end
   // 4 clocks a level: the synchroniser needs 3 to see it
   task automatic hold_level(input int ch, input logic v, input logic clr);
      @(posedge i_core_clk);
      if (clr) o_ext_clear[ch] <= v;
      else o_ext_clk[ch] <= v;
      repeat (4) @(posedge i_core_clk);
   endtask
   task automatic pulse(input int ch, input logic clr);
      hold_level(ch, 1'b1, clr);
      hold_level(ch, 1'b0, clr);
   endtask
endmodule

// [test/tb_top.sv]
// self-checking bench of the dual compare timer
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import dtc_pkg::*;
   logic clk;
   logic rst;
   dtc_axi_req_t axi;
   dtc_axi_rsp_t rsp;
   logic [1:0] ext_clk;
   logic [1:0] ext_clr;
   logic [1:0] xfer_a;
   logic dis_sel;
   logic [1:0] wave;
   logic [1:0] req_a;
   logic [1:0] req_b;
   logic [1:0] req_wrap;
   logic conv;
   int err_total;
   int comparisons;
   int conv_n;
   logic [7:0] os_tab [3] = '{8'h06, 8'h0d, 8'h0e};
   logic wave_tab [3] = '{1'b1, 1'b0, 1'b1};

   dtc_timer dtc_timer_i (.i_core_clk(clk), .i_reset(rst), .i_axi(axi), .o_axi(rsp),
      .i_ext_clk(ext_clk), .i_ext_clear(ext_clr), .i_xfer_start_a(xfer_a),
      .i_xfer_start_b(xfer_a), .i_transfer_disable_select(dis_sel), .o_wave_out(wave),
      .o_match_a_request(req_a), .o_match_b_request(req_b), .o_wrap_request(req_wrap),
      .o_conv_start(conv));
   dtc_partner dtc_partner_i (.i_core_clk(clk), .o_ext_clk(ext_clk), .o_ext_clear(ext_clr));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) if (conv === 1'b1) conv_n++;

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic timeout();
      err_total++;
      complete_run();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      chk({30'h0, got}, {30'h0, exp});
   endtask
   // write and read hold every channel until its own handshake edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      axi.awaddr <= a;
      axi.wdata <= d;
      axi.awvalid <= 1'b1;
      axi.wvalid <= 1'b1;
      axi.bready <= 1'b1;
      for (int n = 0; n < 100; n++) begin
         @(posedge clk);
         if (axi.awvalid && rsp.awready) axi.awvalid <= 1'b0;
         if (axi.wvalid && rsp.wready) axi.wvalid <= 1'b0;
         if (rsp.bvalid === 1'b1) begin
            axi.bready <= 1'b0;
            chk_resp(rsp.bresp, er);
            return;
         end
      end
      timeout();
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge clk);
      axi.araddr <= a;
      axi.arvalid <= 1'b1;
      axi.rready <= 1'b1;
      for (int n = 0; n < 100; n++) begin
         @(posedge clk);
         if (axi.arvalid && rsp.arready) axi.arvalid <= 1'b0;
         if (rsp.rvalid === 1'b1) begin
            axi.rready <= 1'b0;
            chk(rsp.rdata, exp);
            chk_resp(rsp.rresp, er);
            return;
         end
      end
      timeout();
   endtask
   task automatic wait_a(input int ch);
      for (int n = 0; n < 2000; n++) begin
         @(posedge clk);
         if (req_a[ch] === 1'b1) return;
      end
      timeout();
   endtask

   initial begin
      axi = '0;
      axi.wstrb = 4'hf;
      rst = 1'b1;
      xfer_a = 2'h0;
      dis_sel = 1'b0;
      err_total = 0;
      comparisons = 0;
      conv_n = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(DTC_OFS_STOP, 32'h3fff, DTC_RESP_OKAY);
      rd(DTC_OFS_COUNT0, 32'h0, DTC_RESP_SLVERR);
      wr(DTC_OFS_CONSTA0, 32'h3, DTC_RESP_SLVERR);
      wr(8'h2c, 32'h0, DTC_RESP_SLVERR);
      rd(8'h2c, 32'h0, DTC_RESP_SLVERR);
      wr(DTC_OFS_STOP, 32'h0, DTC_RESP_OKAY);
      rd(DTC_OFS_CONSTA0, 32'hff, DTC_RESP_OKAY);
      wr(DTC_OFS_STAT1, 32'h0, DTC_RESP_OKAY);
      rd(DTC_OFS_STAT1, 32'h10, DTC_RESP_OKAY);
      $display("test registers done");
      wr(DTC_OFS_CONSTA0, 32'h3, DTC_RESP_OKAY);
      wr(DTC_OFS_STAT0, 32'h13, DTC_RESP_OKAY);
      wr(DTC_OFS_CTRL0, 32'h49, DTC_RESP_OKAY);
      wait_a(0);
      wr(DTC_OFS_CTRL0, 32'h40, DTC_RESP_OKAY);
      chk({31'h0, wave[0]}, 32'h1);
      chk(conv_n, 32'h1);
      wr(DTC_OFS_STAT0, 32'h13, DTC_RESP_OKAY);
      chk({31'h0, req_a[0]}, 32'h1);
      rd(DTC_OFS_STAT0, 32'h53, DTC_RESP_OKAY);
      wr(DTC_OFS_STAT0, 32'hf3, DTC_RESP_OKAY);
      rd(DTC_OFS_STAT0, 32'h53, DTC_RESP_OKAY);
      wr(DTC_OFS_STAT0, 32'h13, DTC_RESP_OKAY);
      rd(DTC_OFS_STAT0, 32'h13, DTC_RESP_OKAY);
      $display("test internal match done");
      wr(DTC_OFS_COUNT0, 32'hfe, DTC_RESP_OKAY);
      wr(DTC_OFS_CTRL0, 32'h25, DTC_RESP_OKAY);
      repeat (2) dtc_partner_i.pulse(0, 1'b0);
      rd(DTC_OFS_COUNT0, 32'h0, DTC_RESP_OKAY);
      chk({31'h0, req_wrap[0]}, 32'h1);
      wr(DTC_OFS_CTRL0, 32'h27, DTC_RESP_OKAY);
      dtc_partner_i.pulse(0, 1'b0);
      rd(DTC_OFS_COUNT0, 32'h2, DTC_RESP_OKAY);
      wr(DTC_OFS_CTRL0, 32'h26, DTC_RESP_OKAY);
      dtc_partner_i.pulse(0, 1'b0);
      rd(DTC_OFS_COUNT0, 32'h3, DTC_RESP_OKAY);
      wr(DTC_OFS_CTRL0, 32'h1d, DTC_RESP_OKAY);
      dtc_partner_i.pulse(0, 1'b1);
      rd(DTC_OFS_COUNT0, 32'h0, DTC_RESP_OKAY);
      rd(DTC_OFS_STAT0, 32'hb3, DTC_RESP_OKAY);
      wr(DTC_OFS_STAT0, 32'h13, DTC_RESP_OKAY);
      rd(DTC_OFS_STAT0, 32'h13, DTC_RESP_OKAY);
      $display("test external source done");
      wr(DTC_OFS_CONSTA1, 32'h2, DTC_RESP_OKAY);
      wr(DTC_OFS_CONSTB1, 32'h2, DTC_RESP_OKAY);
      for (int i = 0; i < 3; i++) begin
         rd(DTC_OFS_STAT1, (i == 0) ? 32'h10 : {24'h0, 8'hd0 | os_tab[i - 1]},
            DTC_RESP_OKAY);
         wr(DTC_OFS_STAT1, {24'h0, os_tab[i]}, DTC_RESP_OKAY);
         wr(DTC_OFS_CTRL1, 32'hc9, DTC_RESP_OKAY);
         wait_a(1);
         wr(DTC_OFS_CTRL1, 32'hc0, DTC_RESP_OKAY);
         chk({31'h0, wave[1]}, {31'h0, wave_tab[i]});
         chk({31'h0, req_b[1]}, 32'h1);
      end
      // a start with the disable select high must leave the flag
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         dis_sel <= (i == 0);
         xfer_a <= 2'h2;
         @(posedge clk);
         xfer_a <= 2'h0;
         @(posedge clk);
         chk({31'h0, req_a[1]}, (i == 0) ? 32'h1 : 32'h0);
         chk({31'h0, req_b[1]}, (i == 0) ? 32'h1 : 32'h0);
      end
      $display("test output priority done");
      wr(DTC_OFS_COUNT1, 32'hfe, DTC_RESP_OKAY);
      wr(DTC_OFS_COUNT0, 32'h0, DTC_RESP_OKAY);
      wr(DTC_OFS_CTRL0, 32'h4, DTC_RESP_OKAY);
      wr(DTC_OFS_CTRL1, 32'h5, DTC_RESP_OKAY);
      repeat (2) dtc_partner_i.pulse(1, 1'b0);
      rd(DTC_OFS_COUNT1, 32'h0, DTC_RESP_OKAY);
      rd(DTC_OFS_COUNT0, 32'h1, DTC_RESP_OKAY);
      wr(DTC_OFS_CTRL0, 32'h0d, DTC_RESP_OKAY);
      wr(DTC_OFS_CTRL1, 32'h04, DTC_RESP_OKAY);
      repeat (3) dtc_partner_i.pulse(0, 1'b0);
      rd(DTC_OFS_COUNT1, 32'h1, DTC_RESP_OKAY);
      rd(DTC_OFS_COUNT0, 32'h0, DTC_RESP_OKAY);
      $display("test cascade done");
      complete_run();
   end
endmodule
